// ==== verilog/hwd_pkg.sv ====
`default_nettype none
package hwd_pkg;
  // Register byte offsets
  localparam logic [7:0] WDOG_CTRL_OFS = 8'h00;
  localparam logic [7:0] RST_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h0C;
  localparam logic [7:0] WAKE_MASK_OFS = 8'h10;
  // Reset values
  localparam logic [7:0] WDOG_CTRL_RST = 8'h53;
  localparam logic [7:0] RST_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_MASK_RST = 8'h00;
  localparam logic IDLE_ENABLE_RST = 1'b1;
  // Field positions
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam int KEEP_BIT = 7;
  localparam int LOW_SUPPLY_BIT = 2;
  localparam int BAD_THR_BIT = 1;
  localparam int BAD_CODE_BIT = 0;
  localparam int PD_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 6;
  localparam int IDLE_EN_BIT = 0;
  // Enable codes
  localparam logic [4:0] CODE_OFF = 5'h15;
  localparam logic [4:0] CODE_ON = 5'h0A;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_HZ = 100000000;
  localparam int SLOW_OSC_HZ = 32000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam logic [11:0] SLOW_DIV_LAST = 12'(SLOW_DIV - 1);
  localparam logic [1:0] BAD_CODE_TICKS = 2'h3;
  // Power modes
  typedef enum logic [4:0] {
    mode_run = 5'h01,
    mode_sleep0 = 5'h02,
    mode_deep = 5'h04,
    mode_idle_clock_stopped = 5'h08,
    mode_idle_clock_running = 5'h10
  } hwd_mode_t;
  // Watchdog period in slow clock ticks
  function automatic logic [18:0] hwd_period(input logic [2:0] sel);
    case (sel)
      3'h0: hwd_period = 19'h00100;
      3'h1: hwd_period = 19'h00400;
      3'h2: hwd_period = 19'h01000;
      3'h3: hwd_period = 19'h04000;
      3'h4: hwd_period = 19'h08000;
      3'h5: hwd_period = 19'h10000;
      3'h6: hwd_period = 19'h20000;
      default: hwd_period = 19'h40000;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== verilog/hwd_wdog_cnt.sv ====
`timescale 1ns/10ps
`default_nettype none
module hwd_wdog_cnt (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic slow_tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] period_sel,
  // Overflow pulse
  output logic ovf
);
  logic [18:0] cnt_r;
  logic [18:0] last;

  always_comb begin
    last = 19'(hwd_pkg::hwd_period(period_sel) - 19'h00001);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_r <= 19'h00000;
      ovf <= 1'b0;
    end else if (run && slow_tick) begin
      ovf <= (cnt_r >= last);
      cnt_r <= (cnt_r >= last) ? 19'h00000 : 19'(cnt_r + 19'h00001);
    end else begin
      ovf <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/hwd_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module hwd_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // CPU side
  input wire logic halt_exec,
  input wire logic wdog_clr_exec,
  input wire logic irq_req,
  input wire logic irq_enabled,
  input wire logic stack_full,
  // Port A and supply monitors
  input wire logic [7:0] port_a,
  input wire logic lvd_on,
  input wire logic low_supply_evt,
  input wire logic bad_threshold_evt,
  // Clock gating and resets
  output logic sys_clk_en,
  output logic tbc_clk_en,
  output logic wdog_clk_en,
  output logic cpu_halted,
  output logic resume_pulse,
  output logic irq_take,
  output logic pc_sp_reset,
  output logic mcu_reset,
  output logic powerdown_flag,
  output logic wdog_expired_flag
);
  hwd_pkg::hwd_mode_t mode_r;
  hwd_pkg::hwd_mode_t mode_nxt;
  logic [7:0] wdog_ctrl_r;
  logic idle_clock_keep_r;
  logic low_supply_flag_r;
  logic bad_threshold_flag_r;
  logic bad_code_flag_r;
  logic idle_enable_r;
  logic [7:0] pin_wake_mask_r;
  logic [7:0] port_prev_r;
  logic irq_block_r;
  logic [11:0] div_r;
  logic slow_tick;
  logic [1:0] bad_cnt_r;
  logic [4:0] code;
  logic wdog_en;
  logic code_bad;
  logic bad_fire;
  logic ovf;
  logic halt_go;
  logic port_fall;
  logic irq_wake;
  logic wake;
  logic wd_clear;
  logic wr_go;
  logic rd_go;
  logic wr_ctrl;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic rd_hit;
  assign code = wdog_ctrl_r[hwd_pkg::CODE_MSB:hwd_pkg::CODE_LSB];
  assign wdog_en = (code == hwd_pkg::CODE_ON);
  assign code_bad = (code != hwd_pkg::CODE_ON) && (code != hwd_pkg::CODE_OFF);
  assign halt_go = halt_exec && (mode_r == hwd_pkg::mode_run);
  assign port_fall = |(port_prev_r & ~port_a & pin_wake_mask_r);
  assign irq_wake = irq_req && !irq_block_r;
  assign wake = (mode_r != hwd_pkg::mode_run) && (port_fall || irq_wake || ovf);
  assign bad_fire = code_bad && slow_tick && (bad_cnt_r == 2'(hwd_pkg::BAD_CODE_TICKS - 2'h1));
  assign wd_clear = wdog_clr_exec || halt_go || bad_fire;
  // Clock enables per mode
  assign sys_clk_en = (mode_r == hwd_pkg::mode_run) || (mode_r == hwd_pkg::mode_idle_clock_running);
  assign tbc_clk_en = (mode_r == hwd_pkg::mode_run) || (mode_r == hwd_pkg::mode_idle_clock_stopped)
    || (mode_r == hwd_pkg::mode_idle_clock_running);
  assign wdog_clk_en = (mode_r != hwd_pkg::mode_sleep0);
  assign cpu_halted = (mode_r != hwd_pkg::mode_run);
  // Slow oscillator tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 12'h000;
    end else begin
      div_r <= (div_r == hwd_pkg::SLOW_DIV_LAST) ? 12'h000 : 12'(div_r + 12'h001);
    end
  end
  assign slow_tick = (div_r == hwd_pkg::SLOW_DIV_LAST);
  hwd_wdog_cnt u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_tick(slow_tick),
    .run(wdog_en && wdog_clk_en),
    .clear(wd_clear),
    .period_sel(wdog_ctrl_r[hwd_pkg::SEL_MSB:0]),
    .ovf(ovf)
  );
  // Mode selection
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      hwd_pkg::mode_run: begin
        if (halt_go) begin
          if (idle_enable_r) begin
            mode_nxt = idle_clock_keep_r ? hwd_pkg::mode_idle_clock_running : hwd_pkg::mode_idle_clock_stopped;
          end else if (wdog_en || lvd_on) begin
            mode_nxt = hwd_pkg::mode_deep;
          end else begin
            mode_nxt = hwd_pkg::mode_sleep0;
          end
        end
      end
      hwd_pkg::mode_sleep0, hwd_pkg::mode_deep, hwd_pkg::mode_idle_clock_stopped, hwd_pkg::mode_idle_clock_running: begin
        if (wake) begin
          mode_nxt = hwd_pkg::mode_run;
        end
      end
      default: mode_nxt = hwd_pkg::mode_run;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mcu_reset) begin
      mode_r <= hwd_pkg::mode_run;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  // Wake source edges and pending interrupt block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_prev_r <= 8'h00;
      irq_block_r <= 1'b0;
    end else begin
      port_prev_r <= port_a;
      if (halt_go) begin
        irq_block_r <= irq_req;
      end else if (!irq_req) begin
        irq_block_r <= 1'b0;
      end
    end
  end
  // Wake actions and resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_pulse <= 1'b0;
      irq_take <= 1'b0;
      pc_sp_reset <= 1'b0;
      mcu_reset <= 1'b0;
    end else begin
      pc_sp_reset <= wake && ovf;
      resume_pulse <= wake && !ovf && (port_fall || !irq_enabled || stack_full);
      irq_take <= wake && !ovf && !port_fall && irq_enabled && !stack_full;
      mcu_reset <= bad_fire || (ovf && (mode_r == hwd_pkg::mode_run));
    end
  end
  // Illegal code delay
  always_ff @(posedge aclk) begin
    if (!aresetn || !code_bad) begin
      bad_cnt_r <= 2'h0;
    end else if (slow_tick) begin
      bad_cnt_r <= bad_fire ? 2'h0 : 2'(bad_cnt_r + 2'h1);
    end
  end
  // Status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_flag <= 1'b0;
      wdog_expired_flag <= 1'b0;
    end else begin
      if (halt_go) begin
        powerdown_flag <= 1'b1;
      end else if (wdog_clr_exec) begin
        powerdown_flag <= 1'b0;
      end
      if (ovf) begin
        wdog_expired_flag <= 1'b1;
      end else if (halt_go) begin
        wdog_expired_flag <= 1'b0;
      end
    end
  end
  // AXI4-Lite write channel
  assign awready = awvalid && wvalid && !bvalid;
  assign wready = awready;
  assign wr_go = awready;
  assign wb = wstrb[0] ? wdata[7:0] : 8'h00;
  assign wr_ctrl = wr_go && wstrb[0] && (awaddr == hwd_pkg::RST_CTRL_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= hwd_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (awaddr == hwd_pkg::WDOG_CTRL_OFS || awaddr == hwd_pkg::RST_CTRL_OFS
        || awaddr == hwd_pkg::STATUS_OFS || awaddr == hwd_pkg::MODE_CTRL_OFS
        || awaddr == hwd_pkg::WAKE_MASK_OFS) ? hwd_pkg::RESP_OKAY : hwd_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // Watchdog control register
  always_ff @(posedge aclk) begin
    if (!aresetn || mcu_reset) begin
      wdog_ctrl_r <= hwd_pkg::WDOG_CTRL_RST;
    end else if (wr_go && wstrb[0] && awaddr == hwd_pkg::WDOG_CTRL_OFS) begin
      wdog_ctrl_r <= wb;
    end
  end
  // Reset flag register, flags survive internal resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_clock_keep_r <= hwd_pkg::RST_CTRL_RST[hwd_pkg::KEEP_BIT];
      low_supply_flag_r <= hwd_pkg::RST_CTRL_RST[hwd_pkg::LOW_SUPPLY_BIT];
      bad_threshold_flag_r <= hwd_pkg::RST_CTRL_RST[hwd_pkg::BAD_THR_BIT];
      bad_code_flag_r <= hwd_pkg::RST_CTRL_RST[hwd_pkg::BAD_CODE_BIT];
    end else begin
      if (wr_ctrl) begin
        idle_clock_keep_r <= wb[hwd_pkg::KEEP_BIT];
      end
      if (low_supply_evt) begin
        low_supply_flag_r <= 1'b1;
      end else if (wr_ctrl && !wb[hwd_pkg::LOW_SUPPLY_BIT]) begin
        low_supply_flag_r <= 1'b0;
      end
      if (bad_threshold_evt) begin
        bad_threshold_flag_r <= 1'b1;
      end else if (wr_ctrl && !wb[hwd_pkg::BAD_THR_BIT]) begin
        bad_threshold_flag_r <= 1'b0;
      end
      if (bad_fire) begin
        bad_code_flag_r <= 1'b1;
      end else if (wr_ctrl && !wb[hwd_pkg::BAD_CODE_BIT]) begin
        bad_code_flag_r <= 1'b0;
      end
    end
  end
  // Mode control and wake mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_enable_r <= hwd_pkg::IDLE_ENABLE_RST;
      pin_wake_mask_r <= hwd_pkg::WAKE_MASK_RST;
    end else if (wr_go && wstrb[0]) begin
      if (awaddr == hwd_pkg::MODE_CTRL_OFS) begin
        idle_enable_r <= wb[hwd_pkg::IDLE_EN_BIT];
      end
      if (awaddr == hwd_pkg::WAKE_MASK_OFS) begin
        pin_wake_mask_r <= wb;
      end
    end
  end
  // AXI4-Lite read channel
  assign arready = !rvalid;
  assign rd_go = arvalid && arready;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (araddr)
      hwd_pkg::WDOG_CTRL_OFS: rd_byte = wdog_ctrl_r;
      hwd_pkg::RST_CTRL_OFS: rd_byte = {idle_clock_keep_r, 4'h0, low_supply_flag_r,
        bad_threshold_flag_r, bad_code_flag_r};
      hwd_pkg::STATUS_OFS: rd_byte = {1'b0, mode_r, wdog_expired_flag, powerdown_flag};
      hwd_pkg::MODE_CTRL_OFS: rd_byte = {7'h00, idle_enable_r};
      hwd_pkg::WAKE_MASK_OFS: rd_byte = pin_wake_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= hwd_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_hit ? hwd_pkg::RESP_OKAY : hwd_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_halt_run;
    halt_exec && mode_r == hwd_pkg::mode_run && !mcu_reset;
  endsequence
  property p_deep_entry;
    s_halt_run ##0 (!idle_enable_r && (wdog_en || lvd_on))
      |=> mode_r == hwd_pkg::mode_deep && !sys_clk_en && !tbc_clk_en && wdog_clk_en;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep halt entry wrong");
  property p_idle_clock_stopped_entry;
    s_halt_run ##0 (idle_enable_r && !idle_clock_keep_r)
      |=> mode_r == hwd_pkg::mode_idle_clock_stopped && !sys_clk_en && tbc_clk_en;
  endproperty
  a_idle_clock_stopped_entry: assert property (p_idle_clock_stopped_entry) else $error("idle_clock_stopped entry wrong");
  property p_idle_clock_running_entry;
    s_halt_run ##0 (idle_enable_r && idle_clock_keep_r)
      |=> mode_r == hwd_pkg::mode_idle_clock_running && sys_clk_en && tbc_clk_en && cpu_halted;
  endproperty
  a_idle_clock_running_entry: assert property (p_idle_clock_running_entry) else $error("idle_clock_running entry wrong");
  property p_halt_flags;
    s_halt_run ##0 !ovf |=> powerdown_flag && !wdog_expired_flag;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_port_wake;
    mode_r != hwd_pkg::mode_run && port_fall && !ovf && !mcu_reset
      |=> mode_r == hwd_pkg::mode_run && resume_pulse && !irq_take;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("port wake wrong");
  property p_sleep_ovf;
    mode_r != hwd_pkg::mode_run && ovf && !mcu_reset
      |=> pc_sp_reset && wdog_expired_flag && !mcu_reset && $stable(wdog_ctrl_r);
  endproperty
  a_sleep_ovf: assert property (p_sleep_ovf) else $error("halted timeout wrong");
  property p_run_ovf;
    mode_r == hwd_pkg::mode_run && ovf |=> mcu_reset && wdog_expired_flag ##1
      wdog_ctrl_r == hwd_pkg::WDOG_CTRL_RST;
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("run timeout wrong");
  property p_bad_code;
    bad_fire |=> mcu_reset && bad_code_flag_r ##1 wdog_ctrl_r == hwd_pkg::WDOG_CTRL_RST;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code reset wrong");
  property p_flag_hold;
    bad_code_flag_r && !(wr_ctrl && !wb[hwd_pkg::BAD_CODE_BIT]) |=> bad_code_flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("bad code flag lost");
  property p_pending_irq;
    mode_r != hwd_pkg::mode_run && irq_block_r && !port_fall && !ovf && !mcu_reset
      |=> cpu_halted;
  endproperty
  a_pending_irq: assert property (p_pending_irq) else $error("pending irq woke");
endmodule
`default_nettype wire

// ==== test/test_halt_wake_watchdog.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_halt_wake_watchdog;
  // Clock, reset, bus
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  // CPU and pins
  logic halt_exec = 1'b0;
  logic wdog_clr_exec = 1'b0;
  logic irq_req = 1'b0;
  logic irq_enabled = 1'b0;
  logic stack_full = 1'b0;
  logic [7:0] port_a = 8'hFF;
  logic lvd_on = 1'b0;
  logic low_supply_evt = 1'b0;
  logic bad_threshold_evt = 1'b0;
  logic sys_clk_en, tbc_clk_en, wdog_clk_en, cpu_halted, resume_pulse, irq_take;
  logic pc_sp_reset, mcu_reset, powerdown_flag, wdog_expired_flag;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  hwd_top hwd_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .halt_exec(halt_exec), .wdog_clr_exec(wdog_clr_exec), .irq_req(irq_req),
    .irq_enabled(irq_enabled), .stack_full(stack_full), .port_a(port_a), .lvd_on(lvd_on),
    .low_supply_evt(low_supply_evt), .bad_threshold_evt(bad_threshold_evt),
    .sys_clk_en(sys_clk_en), .tbc_clk_en(tbc_clk_en), .wdog_clk_en(wdog_clk_en),
    .cpu_halted(cpu_halted), .resume_pulse(resume_pulse), .irq_take(irq_take),
    .pc_sp_reset(pc_sp_reset), .mcu_reset(mcu_reset), .powerdown_flag(powerdown_flag),
    .wdog_expired_flag(wdog_expired_flag));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    #1;
    while (awready !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    #1;
    while (bvalid !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    check({30'h0, bresp}, {30'h0, er}, "write response");
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    #1;
    while (arready !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    #1;
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
    axi_read(a);
    check(rd, {24'h0, exp}, msg);
    check({30'h0, rs}, {30'h0, hwd_pkg::RESP_OKAY}, "read response");
  endtask

  // Halt and check the clock enables that the mode keeps
  task automatic do_halt(input logic [2:0] clks);
    @(posedge aclk);
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
    #1;
    check({29'h0, sys_clk_en, tbc_clk_en, wdog_clk_en}, {29'h0, clks}, "clock enables");
    check({30'h0, cpu_halted, powerdown_flag}, 32'h3, "halted and powerdown");
    check({31'h0, wdog_expired_flag}, 32'h0, "expired flag");
  endtask

  // Wait for one resume kind: {resume, irq_take, pc_sp_reset}
  task automatic wait_wake(input logic [2:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n = n + 1;
    end while ((resume_pulse | irq_take | pc_sp_reset) !== 1'b1 && n < 20);
    check({29'h0, resume_pulse, irq_take, pc_sp_reset}, {29'h0, exp}, "wake kind");
    check({31'h0, cpu_halted}, 32'h0, "running after wake");
  endtask

  task automatic t_reset_values();
    read_check(hwd_pkg::WDOG_CTRL_OFS, 8'h53, "wdog ctrl reset");
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h00, "reset flags reset");
    read_check(hwd_pkg::STATUS_OFS, 8'h04, "status reset");
    read_check(hwd_pkg::MODE_CTRL_OFS, 8'h01, "idle enable reset");
    read_check(hwd_pkg::WAKE_MASK_OFS, 8'h00, "wake mask reset");
    axi_read(8'h20);
    check({30'h0, rs}, {30'h0, hwd_pkg::RESP_SLVERR}, "unmapped read");
    axi_write(8'h20, 8'hFF, hwd_pkg::RESP_SLVERR);
    $display("test reset values done");
  endtask

  task automatic t_flag_reg();
    @(posedge aclk);
    low_supply_evt <= 1'b1;
    bad_threshold_evt <= 1'b1;
    @(posedge aclk);
    low_supply_evt <= 1'b0;
    bad_threshold_evt <= 1'b0;
    axi_write(hwd_pkg::RST_CTRL_OFS, 8'hFF, hwd_pkg::RESP_OKAY);
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h86, "flags and unused bits");
    axi_write(hwd_pkg::RST_CTRL_OFS, 8'h80, hwd_pkg::RESP_OKAY);
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h80, "flags cleared by zero");
    $display("test flag register done");
  endtask

  task automatic t_idle_clock_running_port();
    axi_write(hwd_pkg::WAKE_MASK_OFS, 8'h01, hwd_pkg::RESP_OKAY);
    do_halt(3'h7);
    @(posedge aclk);
    port_a <= 8'hFD;
    repeat (5) @(posedge aclk);
    #1;
    check({31'h0, cpu_halted}, 32'h1, "unmasked pin no wake");
    @(posedge aclk);
    port_a <= 8'hFC;
    wait_wake(3'h4);
    @(posedge aclk);
    port_a <= 8'hFF;
    $display("test idle_clock_running port wake done");
  endtask

  task automatic t_idle_clock_stopped_irq();
    axi_write(hwd_pkg::RST_CTRL_OFS, 8'h00, hwd_pkg::RESP_OKAY);
    @(posedge aclk);
    irq_req <= 1'b1;
    irq_enabled <= 1'b1;
    do_halt(3'h3);
    repeat (5) @(posedge aclk);
    #1;
    check({31'h0, cpu_halted}, 32'h1, "pending irq no wake");
    @(posedge aclk);
    irq_req <= 1'b0;
    repeat (2) @(posedge aclk);
    irq_req <= 1'b1;
    wait_wake(3'h2);
    @(posedge aclk);
    irq_req <= 1'b0;
    $display("test idle_clock_stopped irq wake done");
  endtask

  task automatic t_deep_irq();
    axi_write(hwd_pkg::MODE_CTRL_OFS, 8'h00, hwd_pkg::RESP_OKAY);
    @(posedge aclk);
    irq_enabled <= 1'b0;
    do_halt(3'h1);
    read_check(hwd_pkg::STATUS_OFS, 8'h11, "deep status");
    irq_req <= 1'b1;
    wait_wake(3'h4);
    @(posedge aclk);
    irq_req <= 1'b0;
    irq_enabled <= 1'b1;
    stack_full <= 1'b1;
    do_halt(3'h1);
    @(posedge aclk);
    irq_req <= 1'b1;
    wait_wake(3'h4);
    @(posedge aclk);
    irq_req <= 1'b0;
    stack_full <= 1'b0;
    wdog_clr_exec <= 1'b1;
    @(posedge aclk);
    wdog_clr_exec <= 1'b0;
    @(posedge aclk);
    #1;
    check({31'h0, powerdown_flag}, 32'h0, "clear instruction");
    $display("test deep halt done");
  endtask

  task automatic t_sleep0();
    axi_write(hwd_pkg::WDOG_CTRL_OFS, 8'hAB, hwd_pkg::RESP_OKAY);
    do_halt(3'h0);
    @(posedge aclk);
    port_a <= 8'hFE;
    wait_wake(3'h4);
    @(posedge aclk);
    port_a <= 8'hFF;
    lvd_on <= 1'b1;
    do_halt(3'h1);
    @(posedge aclk);
    port_a <= 8'hFE;
    wait_wake(3'h4);
    @(posedge aclk);
    port_a <= 8'hFF;
    lvd_on <= 1'b0;
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h00, "disable code no reset");
    $display("test sleep0 done");
  endtask

  task automatic t_bad_code();
    int n;
    axi_write(hwd_pkg::WDOG_CTRL_OFS, 8'h00, hwd_pkg::RESP_OKAY);
    n = 0;
    while (mcu_reset !== 1'b1 && n < 12000) begin
      @(posedge aclk);
      #1;
      n = n + 1;
    end
    check({31'h0, n >= 6240 && n <= 9400}, 32'h1, "illegal code delay");
    axi_read(hwd_pkg::WDOG_CTRL_OFS);
    check(rd, 32'h53, "wdog ctrl after reset");
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h01, "bad code flag");
    axi_write(hwd_pkg::RST_CTRL_OFS, 8'h00, hwd_pkg::RESP_OKAY);
    read_check(hwd_pkg::RST_CTRL_OFS, 8'h00, "bad code flag cleared");
    $display("test illegal code done");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_flag_reg();
    t_idle_clock_running_port();
    t_idle_clock_stopped_irq();
    t_deep_irq();
    t_sleep0();
    t_bad_code();
    final_report();
  end
endmodule
`default_nettype wire
